// ===== sim/ext_dev_model.sv
// Behavioural external parallel device that answers the port's strobes.
`timescale 1ns/10ps
module ext_dev_model (
   input wire logic clk,
   input wire logic m1,
   input wire logic [3:0] act,
   input wire logic [7:0] dout,
   input wire logic doe,
   input wire logic [15:0] addr,
   input wire logic cs,
   input wire logic wr,
   input wire logic rd,
   input wire logic al,
   output logic [7:0] din,
   output logic [7:0] wbyte_r,
   output logic [15:0] waddr_r,
   output logic [7:0] latch_r,
   output logic [7:0] hits_r
);
   logic sel;
   logic wr_hit;
   logic rd_hit;
   logic tgl_r = 1'h0;
   // Levels in act are {latch, select, write or enable, read or direction}
   assign sel = (cs == act[2]);
   assign wr_hit = sel && wr == act[1] && !(m1 && rd == act[0]);
   assign rd_hit = sel && (m1 ? wr == act[1] && rd == act[0] : rd == act[0]);
   // Read answer is a known function of the address; outside it the bus churns
   assign din = rd_hit ? addr[7:0] ^ 8'h5A : {8{tgl_r}};
   initial begin
      wbyte_r = 8'h00;
      waddr_r = 16'h0000;
      latch_r = 8'h00;
      hits_r = 8'h00;
   end
   // Capture each strobe once, and the latched address byte
   always @(posedge clk) begin
      tgl_r <= ~tgl_r;
      if (wr_hit) begin
         wbyte_r <= dout;
         waddr_r <= addr;
      end
      if (wr_hit || rd_hit) begin
         hits_r <= hits_r + 8'h01;
      end
      if (doe && al == act[3]) begin
         latch_r <= dout;
      end
   end
endmodule : ext_dev_model

// ===== sim/parallel_master_port_ctrl_tb.sv
// Self-checking bench: APB set-up of the port and traffic to an external device.
`timescale 1ns/10ps
module parallel_master_port_ctrl_tb;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] act = 4'h0;
   logic m1 = 1'h0;
   logic idle_req = 1'h0;
   logic cs_in = 1'h0;
   logic wr_in = 1'h0;
   logic rd_in = 1'h0;
   logic slv_on = 1'h0;
   logic [7:0] slv_byte = 8'h00;
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] prdata;
   logic pready, pslverr, port_data_oe, chip_select_out, chip_select_oe;
   logic write_strobe_out, write_strobe_oe, read_strobe_out, read_strobe_oe;
   logic byte_enable_out, byte_enable_oe, addr_latch_out, addr_latch_oe;
   logic [7:0] port_data_out, port_data_in, wbyte, latch, hits, dev_din;
   logic [15:0] port_address_pins, port_address_oe, waddr;
   // Undriven control pins settle at their inactive level
   wire cs_w = chip_select_oe ? chip_select_out : !act[2];
   wire wr_w = write_strobe_oe ? write_strobe_out : !act[1];
   wire rd_w = read_strobe_oe ? read_strobe_out : !act[0];
   wire al_w = addr_latch_oe ? addr_latch_out : !act[3];
   // Slave scenarios put the external master's byte on the data pins
   assign port_data_in = slv_on ? slv_byte : dev_din;
   parallel_master_port_ctrl dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .idle_req, .port_data_in, .port_data_out,
      .port_data_oe, .port_address_pins, .port_address_oe, .chip_select_out, .chip_select_oe,
      .chip_select_in(cs_in), .write_strobe_out, .write_strobe_oe, .write_strobe_in(wr_in),
      .read_strobe_out, .read_strobe_oe, .read_strobe_in(rd_in), .byte_enable_out,
      .byte_enable_oe, .addr_latch_out, .addr_latch_oe);
   ext_dev_model partner (.clk, .m1, .act, .dout(port_data_out), .doe(port_data_oe),
      .addr(port_address_pins), .cs(cs_w), .wr(wr_w), .rd(rd_w), .al(al_w),
      .din(dev_din), .wbyte_r(wbyte), .waddr_r(waddr), .latch_r(latch), .hits_r(hits));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, ex, got);
      end
   endtask : chk
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 50) begin
         chk("pready", 32'h1, 32'h0);
         tally_and_finish;
      end
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'h1, a, d, q, e);
   endtask : wr
   task automatic wait_idle;
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'h0, pport_pkg::OFS_STAT, 32'h0, q, e);
         n++;
      end while ((q[0] !== 1'h0 || q[4:3] !== 2'h0) && n < 40);
      if (q[0] !== 1'h0 || q[4:3] !== 2'h0) begin
         chk("idle", 32'h0, q);
         tally_and_finish;
      end
   endtask : wait_idle
   function automatic logic [15:0] ctl(input logic [3:0] ac);
      ctl = 16'h8780 | {10'h0, ac[3], 1'h0, ac[2], 1'h0, ac[1], ac[0]};
   endfunction : ctl
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      apb(1'h0, pport_pkg::OFS_CTRL, 32'h0, q, e);
      chk("ctrl reset", 32'h0, q);
      wr(pport_pkg::OFS_CTRL, 32'h0000FFFF);
      apb(1'h0, pport_pkg::OFS_CTRL, 32'h0, q, e);
      chk("ctrl mask", 32'h0000BFEF, q);
      wr(pport_pkg::OFS_CTRL, 32'h0);
      apb(1'h0, 8'h20, 32'h0, q, e);
      chk("unmapped", 32'h1, {q[30:0], e});
   endtask : t_regs
   // Write then read one byte in a given mode and polarity set
   task automatic xfer(input logic [1:0] md, input logic [3:0] ac, input logic [15:0] a,
      input logic [7:0] d);
      logic [31:0] q;
      logic e;
      logic [7:0] h;
      act <= ac;
      m1 <= (md == pport_pkg::MODE_M1);
      wr(pport_pkg::OFS_MODE, {30'h0, md});
      wr(pport_pkg::OFS_CTRL, {16'h0, ctl(ac)});
      wr(pport_pkg::OFS_ADDR, {16'h0, a});
      h = hits;
      wr(pport_pkg::OFS_WDATA, {24'h0, d});
      wait_idle;
      chk("wbyte", {24'h0, d}, {24'h0, wbyte});
      chk("waddr", {16'h0, a}, {16'h0, waddr});
      chk("be idle", 32'h3, {30'h0, byte_enable_oe, byte_enable_out});
      wr(pport_pkg::OFS_RCMD, 32'h0);
      wait_idle;
      apb(1'h0, pport_pkg::OFS_WDATA, 32'h0, q, e);
      chk("rdata", {24'h0, a[7:0] ^ 8'h5A}, q);
      chk("hits", {24'h0, h + 8'h02}, {24'h0, hits});
   endtask : xfer
   // Multiplexed address: the latch strobe carries the address on the data pins
   task automatic t_mux(input logic [1:0] mx, input logic [15:0] a, input logic [7:0] d);
      act <= 4'hC;
      m1 <= 1'h0;
      wr(pport_pkg::OFS_MODE, {30'h0, pport_pkg::MODE_M2});
      wr(pport_pkg::OFS_CTRL, {16'h0, ctl(4'hC) | {3'h0, mx, 11'h0}});
      wr(pport_pkg::OFS_ADDR, {16'h0, a});
      wr(pport_pkg::OFS_WDATA, {24'h0, d});
      wait_idle;
      chk("latch", {24'h0, a[7:0]}, {24'h0, latch});
      chk("addr hi", {29'h0, a[10:8]}, {29'h0, waddr[10:8]});
      chk("wbyte mux", {24'h0, d}, {24'h0, wbyte});
      chk("addr oe", (mx == pport_pkg::MUX_LO8) ? 32'h0700 : 32'h0, {16'h0, port_address_oe});
   endtask : t_mux
   // External master writes a byte, then reads the transmit byte back
   task automatic t_slave(input logic [1:0] md, input logic [7:0] b);
      logic [31:0] q;
      logic e;
      wr(pport_pkg::OFS_MODE, {30'h0, md});
      wr(pport_pkg::OFS_CTRL, 32'h0000800B);
      wr(pport_pkg::OFS_SLAVE, {24'h0, ~b});
      slv_on <= 1'h1;
      slv_byte <= b;
      cs_in <= 1'h1;
      wr_in <= 1'h1;
      repeat (2) @(posedge clk);
      wr_in <= 1'h0;
      rd_in <= 1'h1;
      repeat (2) @(posedge clk);
      chk("slave drive", {23'h0, 1'h1, ~b}, {23'h0, port_data_oe, port_data_out});
      cs_in <= 1'h0;
      rd_in <= 1'h0;
      slv_on <= 1'h0;
      @(posedge clk);
      apb(1'h0, pport_pkg::OFS_STAT, 32'h0, q, e);
      chk("slave flag", 32'h4, q & 32'h4);
      apb(1'h0, pport_pkg::OFS_SLAVE, 32'h0, q, e);
      chk("slave byte", {24'h0, b}, q);
      apb(1'h0, pport_pkg::OFS_STAT, 32'h0, q, e);
      chk("flag clear", 32'h0, q & 32'h4);
   endtask : t_slave
   // Disabled port keeps the command queued and leaves the pins alone
   task automatic t_off;
      logic [31:0] q;
      logic e;
      logic [7:0] h;
      h = hits;
      wr(pport_pkg::OFS_CTRL, {16'h0, ctl(4'h4) & 16'h7FFF});
      wr(pport_pkg::OFS_WDATA, 32'h0000005D);
      repeat (20) @(posedge clk);
      apb(1'h0, pport_pkg::OFS_STAT, 32'h0, q, e);
      chk("queued", 32'h1, {30'h0, q[4:3]});
      chk("no hits", {24'h0, h}, {24'h0, hits});
      chk("oe off", 32'h0, {14'h0, byte_enable_oe, port_address_oe, port_data_oe});
      // Enabled but held by the idle stop: still no access
      idle_req <= 1'h1;
      wr(pport_pkg::OFS_CTRL, {16'h0, ctl(4'h4) | 16'h2000});
      repeat (20) @(posedge clk);
      apb(1'h0, pport_pkg::OFS_STAT, 32'h0, q, e);
      chk("idle stall", 32'h1, {30'h0, q[4:3]});
      chk("stall hits", {24'h0, h}, {24'h0, hits});
      idle_req <= 1'h0;
      wait_idle;
      chk("late byte", 32'h5D, {24'h0, wbyte});
   endtask : t_off
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      t_regs;
      t_slave(pport_pkg::MODE_LEGACY, 8'h7E);
      t_slave(pport_pkg::MODE_ENH, 8'h81);
      wr(pport_pkg::OFS_PINEN, 32'h0000FFFF);
      xfer(pport_pkg::MODE_M2, 4'h4, 16'h1234, 8'hA5);
      xfer(pport_pkg::MODE_M2, 4'hF, 16'hBEEF, 8'h3C);
      xfer(pport_pkg::MODE_M1, 4'h6, 16'h00C1, 8'h96);
      t_mux(pport_pkg::MUX_LO8, 16'h0567, 8'h3C);
      t_mux(pport_pkg::MUX_FULL, 16'hA2D9, 8'h71);
      t_off;
      tally_and_finish;
   end
endmodule : parallel_master_port_ctrl_tb

// ===== verilog/parallel_master_port_ctrl.sv
// APB-controlled eight-bit parallel master/slave port engine.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module parallel_master_port_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_req,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_out,
   output logic port_data_oe,
   output logic [15:0] port_address_pins,
   output logic [15:0] port_address_oe,
   output logic chip_select_out,
   output logic chip_select_oe,
   input wire logic chip_select_in,
   output logic write_strobe_out,
   output logic write_strobe_oe,
   input wire logic write_strobe_in,
   output logic read_strobe_out,
   output logic read_strobe_oe,
   input wire logic read_strobe_in,
   output logic byte_enable_out,
   output logic byte_enable_oe,
   output logic addr_latch_out,
   output logic addr_latch_oe
);
   logic [15:0] ctrl_r;
   logic [1:0] mode_r;
   logic [15:0] addr_r;
   logic [15:0] pinen_r;
   logic [7:0] rdata_r;
   logic rd_valid_r;
   logic [7:0] slv_rx_r;
   logic [7:0] slv_tx_r;
   logic slv_flag_r;
   logic slv_wr_d_r;
   logic [24:0] fifo_mem [pport_pkg::FIFO_DEPTH];
   logic fifo_wp_r;
   logic fifo_rp_r;
   logic [1:0] fifo_cnt_r;
   pport_pkg::eng_state_type state_r;
   logic cur_rd_r;
   logic [15:0] cur_addr_r;
   logic [7:0] cur_data_r;
   logic en;
   logic master;
   logic slave;
   logic [1:0] mux;
   logic push;
   logic pop;
   logic push_cmd;
   logic apb_done;
   logic strobe;
   logic slv_cs;
   logic slv_rd;
   logic slv_wr;

   // Decoded control fields
   assign en = ctrl_r[pport_pkg::B_EN];
   assign mux = ctrl_r[pport_pkg::B_MUX +: 2];
   assign master = en && (mode_r == pport_pkg::MODE_M1 || mode_r == pport_pkg::MODE_M2);
   assign slave = en && !master;
   assign strobe = (state_r == pport_pkg::ST_STB);
   assign apb_done = psel && penable && pready;
   assign push_cmd = pwrite && (paddr == pport_pkg::OFS_WDATA || paddr == pport_pkg::OFS_RCMD);
   assign push = apb_done && push_cmd;
   // Engine takes a command only when enabled, idle and not stopped for idle
   assign pop = (state_r == pport_pkg::ST_IDLE) && master && (fifo_cnt_r != 2'h0)
      && !(ctrl_r[pport_pkg::B_IDLE] && idle_req);
   // Slave strobes are active when the pin level equals its polarity bit
   assign slv_cs = (chip_select_in == ctrl_r[pport_pkg::B_CSP]);
   assign slv_rd = slave && slv_cs && (read_strobe_in == ctrl_r[pport_pkg::B_READ_STROBE_POLARITY]);
   assign slv_wr = slave && slv_cs && (write_strobe_in == ctrl_r[pport_pkg::B_WRITE_STROBE_POLARITY]);

   function automatic logic lvl(input logic act, input logic pol);
      lvl = pol ? act : ~act;
   endfunction : lvl

   // APB answer: one wait state, longer for a WDATA or RCMD write while the command buffer is full
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         if (!push_cmd || fifo_cnt_r < 2'(pport_pkg::FIFO_DEPTH)) begin
            pready <= 1'b1;
            pslverr <= (paddr > pport_pkg::OFS_PINEN) || (paddr[1:0] != 2'h0);
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read data is prepared in the cycle before pready rises
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready && !pwrite) begin
         if (paddr == pport_pkg::OFS_CTRL) begin
            prdata <= {16'h0000, ctrl_r};
         end else if (paddr == pport_pkg::OFS_MODE) begin
            prdata <= {30'h0000_0000, mode_r};
         end else if (paddr == pport_pkg::OFS_ADDR) begin
            prdata <= {16'h0000, addr_r};
         end else if (paddr == pport_pkg::OFS_WDATA) begin
            prdata <= {24'h00_0000, rdata_r};
         end else if (paddr == pport_pkg::OFS_STAT) begin
            prdata <= {27'h000_0000, fifo_cnt_r, slv_flag_r, rd_valid_r,
               state_r != pport_pkg::ST_IDLE};
         end else if (paddr == pport_pkg::OFS_SLAVE) begin
            prdata <= {24'h00_0000, slv_rx_r};
         end else if (paddr == pport_pkg::OFS_PINEN) begin
            prdata <= {16'h0000, pinen_r};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Software-written configuration; reserved control bits stay zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_r <= pport_pkg::CTRL_RESET;
         mode_r <= pport_pkg::MODE_LEGACY;
         addr_r <= 16'h0000;
         pinen_r <= pport_pkg::PINEN_RESET;
         slv_tx_r <= 8'h00;
      end else if (apb_done && pwrite) begin
         if (paddr == pport_pkg::OFS_CTRL) begin
            ctrl_r <= pwdata[15:0] & pport_pkg::CTRL_WMASK;
         end else if (paddr == pport_pkg::OFS_MODE) begin
            mode_r <= pwdata[1:0];
         end else if (paddr == pport_pkg::OFS_ADDR) begin
            addr_r <= pwdata[15:0];
         end else if (paddr == pport_pkg::OFS_SLAVE) begin
            slv_tx_r <= pwdata[7:0];
         end else if (paddr == pport_pkg::OFS_PINEN) begin
            pinen_r <= pwdata[15:0];
         end
      end
   end

   // Two-entry command buffer of direction, address and data
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fifo_wp_r <= 1'b0;
         fifo_rp_r <= 1'b0;
         fifo_cnt_r <= 2'h0;
      end else begin
         if (push) begin
            fifo_mem[fifo_wp_r] <= {paddr == pport_pkg::OFS_RCMD, addr_r, pwdata[7:0]};
            fifo_wp_r <= ~fifo_wp_r;
         end
         if (pop) begin
            fifo_rp_r <= ~fifo_rp_r;
         end
         fifo_cnt_r <= fifo_cnt_r + 2'(push) - 2'(pop);
      end
   end

   // Access sequencer: address phases, strobe, then sample
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r <= pport_pkg::ST_IDLE;
         cur_rd_r <= 1'b0;
         cur_addr_r <= 16'h0000;
         cur_data_r <= 8'h00;
      end else begin
         case (state_r)
            pport_pkg::ST_IDLE: begin
               if (pop) begin
                  {cur_rd_r, cur_addr_r, cur_data_r} <= fifo_mem[fifo_rp_r];
                  if (mux == pport_pkg::MUX_FULL) begin
                     state_r <= pport_pkg::ST_AHI;
                  end else if (mux == pport_pkg::MUX_LO8) begin
                     state_r <= pport_pkg::ST_ALO;
                  end else begin
                     state_r <= pport_pkg::ST_STB;
                  end
               end
            end
            pport_pkg::ST_AHI: state_r <= pport_pkg::ST_ALO;
            pport_pkg::ST_ALO: state_r <= pport_pkg::ST_STB;
            pport_pkg::ST_STB: state_r <= pport_pkg::ST_END;
            default: state_r <= pport_pkg::ST_IDLE;
         endcase
      end
   end

   // Read result is sampled while the strobe is visible; set beats clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= 8'h00;
         rd_valid_r <= 1'b0;
      end else if (state_r == pport_pkg::ST_END && cur_rd_r) begin
         rdata_r <= port_data_in;
         rd_valid_r <= 1'b1;
      end else if (apb_done && !pwrite && paddr == pport_pkg::OFS_WDATA) begin
         rd_valid_r <= 1'b0;
      end
   end

   // Slave side: data caught while written, flagged at strobe end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         slv_rx_r <= 8'h00;
         slv_flag_r <= 1'b0;
         slv_wr_d_r <= 1'b0;
      end else begin
         slv_wr_d_r <= slv_wr;
         if (slv_wr) begin
            slv_rx_r <= port_data_in;
         end
         if (slv_wr_d_r && !slv_wr) begin
            slv_flag_r <= 1'b1;
         end else if (apb_done && !pwrite && paddr == pport_pkg::OFS_SLAVE) begin
            slv_flag_r <= 1'b0;
         end
      end
   end

   // Pin drivers; every enable drops while the port is off
   always_ff @(posedge clk) begin
      if (!resetn) begin
         chip_select_out <= 1'b0;
         chip_select_oe <= 1'b0;
         write_strobe_out <= 1'b0;
         write_strobe_oe <= 1'b0;
         read_strobe_out <= 1'b0;
         read_strobe_oe <= 1'b0;
         byte_enable_out <= 1'b0;
         byte_enable_oe <= 1'b0;
         addr_latch_out <= 1'b0;
         addr_latch_oe <= 1'b0;
      end else begin
         chip_select_out <= lvl(strobe && ctrl_r[pport_pkg::B_CSF +: 2] == pport_pkg::CSF_CS,
            ctrl_r[pport_pkg::B_CSP]);
         chip_select_oe <= master && ctrl_r[pport_pkg::B_CSF +: 2] == pport_pkg::CSF_CS;
         if (mode_r == pport_pkg::MODE_M1) begin
            // Direction level for the whole access, enable pulse on the strobe
            read_strobe_out <= lvl(cur_rd_r && state_r != pport_pkg::ST_IDLE,
               ctrl_r[pport_pkg::B_READ_STROBE_POLARITY]);
            write_strobe_out <= lvl(strobe, ctrl_r[pport_pkg::B_WRITE_STROBE_POLARITY]);
         end else begin
            read_strobe_out <= lvl(strobe && cur_rd_r, ctrl_r[pport_pkg::B_READ_STROBE_POLARITY]);
            write_strobe_out <= lvl(strobe && !cur_rd_r, ctrl_r[pport_pkg::B_WRITE_STROBE_POLARITY]);
         end
         read_strobe_oe <= master && ctrl_r[pport_pkg::B_RDEN];
         write_strobe_oe <= master && ctrl_r[pport_pkg::B_WREN];
         byte_enable_out <= lvl(strobe, ctrl_r[pport_pkg::B_BEP]);
         byte_enable_oe <= master && ctrl_r[pport_pkg::B_BEEN];
         addr_latch_out <= lvl(state_r == pport_pkg::ST_AHI || state_r == pport_pkg::ST_ALO,
            ctrl_r[pport_pkg::B_ALP]);
         addr_latch_oe <= master && mux != pport_pkg::MUX_NONE;
      end
   end

   // Address and data pins; multiplexed modes drive address on data first
   always_ff @(posedge clk) begin
      if (!resetn) begin
         port_data_out <= 8'h00;
         port_data_oe <= 1'b0;
         port_address_pins <= 16'h0000;
         port_address_oe <= 16'h0000;
      end else begin
         port_address_pins <= cur_addr_r;
         if (!master || mux == pport_pkg::MUX_FULL) begin
            port_address_oe <= 16'h0000;
         end else if (mux == pport_pkg::MUX_LO8) begin
            port_address_oe <= pinen_r & pport_pkg::MUX_LO8_PINS;
         end else begin
            port_address_oe <= pinen_r;
         end
         case (state_r)
            pport_pkg::ST_AHI: begin
               port_data_out <= cur_addr_r[15:8];
               port_data_oe <= 1'b1;
            end
            pport_pkg::ST_ALO: begin
               port_data_out <= cur_addr_r[7:0];
               port_data_oe <= 1'b1;
            end
            pport_pkg::ST_STB: begin
               port_data_out <= cur_data_r;
               port_data_oe <= !cur_rd_r;
            end
            default: begin
               port_data_out <= slv_tx_r;
               port_data_oe <= slv_rd;
            end
         endcase
      end
   end

   sequence strobe_seq;
      state_r == pport_pkg::ST_STB ##1 state_r == pport_pkg::ST_END;
   endsequence

   no_access_off_a: assert property (@(posedge clk) disable iff (!resetn)
      !en |-> ##1 (!port_data_oe || slave) && !chip_select_oe && port_address_oe == 16'h0000)
      else $error("pins driven while port off");
   strobe_order_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe_seq |-> ##1 state_r == pport_pkg::ST_IDLE)
      else $error("strobe phase not closed");
   wr_strobe_lvl_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe && !cur_rd_r && mode_r == pport_pkg::MODE_M2
      |=> write_strobe_out == ctrl_r[pport_pkg::B_WRITE_STROBE_POLARITY])
      else $error("write strobe wrong level");
   m1_rw_lvl_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe && cur_rd_r && mode_r == pport_pkg::MODE_M1
      |=> read_strobe_out == ctrl_r[pport_pkg::B_READ_STROBE_POLARITY]
      && write_strobe_out == ctrl_r[pport_pkg::B_WRITE_STROBE_POLARITY])
      else $error("mode 1 strobe levels wrong");
   mux_lo_data_a: assert property (@(posedge clk) disable iff (!resetn)
      state_r == pport_pkg::ST_ALO |=> port_data_oe && port_data_out == cur_addr_r[7:0])
      else $error("low address missing on data pins");
   write_data_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe && !cur_rd_r |=> port_data_oe && port_data_out == $past(cur_data_r))
      else $error("write data not driven");
   cs_select_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe && ctrl_r[pport_pkg::B_CSF +: 2] == pport_pkg::CSF_CS
      |=> chip_select_out == ctrl_r[pport_pkg::B_CSP])
      else $error("chip select not active");
   addr_pins_a: assert property (@(posedge clk) disable iff (!resetn)
      master && mux == pport_pkg::MUX_NONE |=> port_address_oe == $past(pinen_r))
      else $error("address pins not per enable");
   slave_read_a: assert property (@(posedge clk) disable iff (!resetn)
      slv_rd && state_r == pport_pkg::ST_IDLE |=> port_data_oe && port_data_out == $past(slv_tx_r))
      else $error("slave read data missing");
   // Byte enable follows the strobe at its programmed level
   be_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
      strobe |=> byte_enable_out == ctrl_r[pport_pkg::B_BEP])
      else $error("byte enable not active");
endmodule : parallel_master_port_ctrl

// ===== verilog/pport_pkg.sv
// Constants, register map and field layout of the parallel port unit.
package pport_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_WDATA = 8'h0C;
   localparam logic [7:0] OFS_RCMD = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_SLAVE = 8'h18;
   localparam logic [7:0] OFS_PINEN = 8'h1C;
   // Control register layout
   localparam int B_EN = 15;
   localparam int B_IDLE = 13;
   localparam int B_MUX = 11;
   localparam int B_BEEN = 10;
   localparam int B_WREN = 9;
   localparam int B_RDEN = 8;
   localparam int B_CSF = 6;
   localparam int B_ALP = 5;
   localparam int B_CSP = 3;
   localparam int B_BEP = 2;
   localparam int B_WRITE_STROBE_POLARITY = 1;
   localparam int B_READ_STROBE_POLARITY = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hBFEF;
   localparam logic [15:0] PINEN_RESET = 16'h0000;
   localparam logic [15:0] MUX_LO8_PINS = 16'h0700;
   // Field encodings
   localparam logic [1:0] MODE_LEGACY = 2'h0;
   localparam logic [1:0] MODE_ENH = 2'h1;
   localparam logic [1:0] MODE_M2 = 2'h2;
   localparam logic [1:0] MODE_M1 = 2'h3;
   localparam logic [1:0] MUX_NONE = 2'h0;
   localparam logic [1:0] MUX_LO8 = 2'h1;
   localparam logic [1:0] MUX_FULL = 2'h2;
   localparam logic [1:0] CSF_CS = 2'h2;
   localparam int FIFO_DEPTH = 2;
   typedef enum logic [2:0] {ST_IDLE, ST_AHI, ST_ALO, ST_STB, ST_END} eng_state_type;
endpackage : pport_pkg
